// file: bench/dcf_fifo_checker.sv
// Concurrent checks on the FIFO top-level pins, bound into dcf_fifo.
// Assumes pin clocks are slow pulses against clk_sys_in.
`timescale 1ns/100ps
`default_nettype none

module dcf_fifo_checker #(
  parameter int DEPTH_LOG2 = dcf_pkg::DEPTH_LOG2_DFLT
) (
  input wire logic                       clk_sys_in,                // System clock
  input wire logic                       resetn_in,                 // Chip reset
  input wire logic                       master_reset_n_in,         // Master reset pin
  input wire logic                       write_clk_in,              // Write clock pin
  input wire logic                       write_enable_b_or_load_in, // Enable B or load
  input wire logic                       read_clk_in,               // Read clock pin
  input wire logic                       read_enable_a_n_in,        // Read enable A
  input wire logic                       read_enable_b_n_in,        // Read enable B
  input wire logic                       output_enable_n_in,        // Output enable
  input wire logic [dcf_pkg::DATA_W-1:0] read_data_out,             // Read data
  input wire logic                       read_data_oe_out,          // Drive enable
  input wire logic                       empty_flag_n_out,          // Empty
  input wire logic                       full_flag_n_out,           // Full
  input wire logic                       almost_empty_n_out,        // Almost empty
  input wire logic                       almost_full_n_out          // Almost full
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence s_mr_held; !master_reset_n_in [*4]; endsequence
  sequence s_wr_idle; (!write_clk_in && master_reset_n_in) [*6]; endsequence
  sequence s_rd_idle; (!read_clk_in && master_reset_n_in) [*6]; endsequence
  sequence s_rd_empty;
    (!read_clk_in && !empty_flag_n_out) ##1 (read_clk_in && master_reset_n_in && write_enable_b_or_load_in);
  endsequence

  property p_reset_out;
    s_mr_held |=> (read_data_out == '0) && !empty_flag_n_out && full_flag_n_out
                  && !almost_empty_n_out && almost_full_n_out;
  endproperty
  property p_wr_flags; s_wr_idle |-> $stable(full_flag_n_out) && $stable(almost_full_n_out); endproperty
  property p_rd_flags;
    s_rd_idle |-> $stable(empty_flag_n_out) && $stable(almost_empty_n_out) && $stable(read_data_out);
  endproperty
  property p_rd_empty; s_rd_empty |=> $stable(read_data_out) [*5]; endproperty
  property p_oe_on;
    (!output_enable_n_in && !read_enable_a_n_in && !read_enable_b_n_in) [*3] |-> read_data_oe_out;
  endproperty
  property p_oe_off; output_enable_n_in [*3] |-> !read_data_oe_out; endproperty
  property p_cascade; (read_enable_a_n_in || read_enable_b_n_in) [*3] |-> !read_data_oe_out; endproperty
  property p_full_af; !full_flag_n_out |-> !almost_full_n_out; endproperty
  property p_empty_ae; !empty_flag_n_out |-> !almost_empty_n_out; endproperty

  a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");
  a_wr_flags: assert property (p_wr_flags) else $error("full flags moved");
  a_rd_flags: assert property (p_rd_flags) else $error("empty flags moved");
  a_rd_empty: assert property (p_rd_empty) else $error("data lost");
  a_oe_on: assert property (p_oe_on) else $error("no drive");
  a_oe_off: assert property (p_oe_off) else $error("drive while off");
  a_cascade: assert property (p_cascade) else $error("drive unenabled");
  a_full_af: assert property (p_full_af) else $error("full not almost");
  a_empty_ae: assert property (p_empty_ae) else $error("empty not almost");
endmodule // dcf_fifo_checker

bind dcf_fifo dcf_fifo_checker #(.DEPTH_LOG2(DEPTH_LOG2)) dcf_fifo_checker_i (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .master_reset_n_in(master_reset_n_in),
  .write_clk_in(write_clk_in), .write_enable_b_or_load_in(write_enable_b_or_load_in),
  .read_clk_in(read_clk_in), .read_enable_a_n_in(read_enable_a_n_in), .read_enable_b_n_in(read_enable_b_n_in),
  .output_enable_n_in(output_enable_n_in), .read_data_out(read_data_out), .read_data_oe_out(read_data_oe_out),
  .empty_flag_n_out(empty_flag_n_out), .full_flag_n_out(full_flag_n_out),
  .almost_empty_n_out(almost_empty_n_out), .almost_full_n_out(almost_full_n_out));
`default_nettype wire

// file: bench/dcf_pin_model.sv
// Writer and reader logic driving the FIFO pins one pulsed clock per transfer.
// Assumes callers run one task at a time from the bench.
`timescale 1ns/100ps
`default_nettype none

module dcf_pin_model (
  input  wire logic                       clk_sys_in,   // System clock
  output logic                            wclk_out,     // Write clock pin
  output logic                            wena_n_out,   // Write enable A
  output logic                            wenb_out,     // Enable B or load
  output logic      [dcf_pkg::DATA_W-1:0] wdata_out,    // Write data
  output logic                            rclk_out,     // Read clock pin
  output logic                            rena_n_out,   // Read enable A
  output logic                            renb_n_out,   // Read enable B
  output logic                            done_out      // Result ready pulse
);
  logic enb_idle;

  initial begin
    {wclk_out, rclk_out, done_out} = 3'h0;
    {wena_n_out, wenb_out, rena_n_out, renb_n_out, enb_idle} = 5'h1F;
    wdata_out = 9'h000;
  end

  task automatic set_enb(input logic v);
    @(posedge clk_sys_in);
    enb_idle <= v;
    wenb_out <= v;
  endtask

  // Enables and data held from before the edge to past the answer
  task automatic wr_xfer(input logic ena_n, input logic enb, input logic [8:0] d);
    @(posedge clk_sys_in);
    wena_n_out <= ena_n;
    wenb_out   <= enb;
    wdata_out  <= d;
    repeat (2) @(posedge clk_sys_in);
    wclk_out <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    wclk_out <= 1'b0;
    done_out <= 1'b1;
    @(posedge clk_sys_in);
    done_out   <= 1'b0;
    wena_n_out <= 1'b1;
    wenb_out   <= enb_idle;
    wdata_out  <= ~d;
    repeat (2) @(posedge clk_sys_in);
  endtask

  task automatic rd_xfer(input logic ena_n, input logic enb_n);
    @(posedge clk_sys_in);
    rena_n_out <= ena_n;
    renb_n_out <= enb_n;
    repeat (2) @(posedge clk_sys_in);
    rclk_out <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    rclk_out <= 1'b0;
    done_out <= 1'b1;
    @(posedge clk_sys_in);
    done_out   <= 1'b0;
    rena_n_out <= 1'b1;
    renb_n_out <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
  endtask
endmodule // dcf_pin_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench: notes expected pin state per transfer, monitor compares.
// Assumes a 16-word build and the pin model partner.
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int DLOG  = 4;
  localparam int DEPTH = 1 << DLOG;
  typedef struct packed {
    logic [8:0] d;
    logic       oe;
    logic       ef;
    logic       ff;
    logic       almost_empty_n;
    logic       almost_full_n;
  } dcf_snap_t;

  logic       clk_sys_in, resetn_in, mr_n, oe_n, probe, ld_cfg, enb_lvl;
  logic       w_clk, w_ena_n, w_enb, r_clk, r_ena_n, r_enb_n, pm_done;
  logic       rd_oe, ef_n, ff_n, pae_n, paf_n;
  logic [8:0] w_data, rd_data;
  logic [8:0] ofs[4];
  logic [8:0] model[$];
  logic [8:0] vals[5] = '{9'h003, 9'h000, 9'h002, 9'h000, 9'h004};
  logic [15:0] seed = 16'h0043;
  dcf_snap_t  notes[$];
  dcf_snap_t  ex;
  int         pos;
  int         num_errors = 0;
  int         compares = 0;

  dcf_fifo #(.DEPTH_LOG2(DLOG)) dcf_fifo_i (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .master_reset_n_in(mr_n), .write_clk_in(w_clk),
    .write_enable_a_n_in(w_ena_n), .write_enable_b_or_load_in(w_enb), .write_data_in(w_data),
    .read_clk_in(r_clk), .read_enable_a_n_in(r_ena_n), .read_enable_b_n_in(r_enb_n),
    .output_enable_n_in(oe_n), .read_data_out(rd_data), .read_data_oe_out(rd_oe), .empty_flag_n_out(ef_n),
    .full_flag_n_out(ff_n), .almost_empty_n_out(pae_n), .almost_full_n_out(paf_n));

  dcf_pin_model dcf_pin_model_i (
    .clk_sys_in(clk_sys_in), .wclk_out(w_clk), .wena_n_out(w_ena_n), .wenb_out(w_enb), .wdata_out(w_data),
    .rclk_out(r_clk), .rena_n_out(r_ena_n), .renb_n_out(r_enb_n), .done_out(pm_done));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic complete_run();
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk_snap(input dcf_snap_t got);
    dcf_snap_t want;
    want = notes.pop_front();
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic do_wr(input logic ena, input logic enb, input logic [8:0] d);
    if (ld_cfg && !ena && !enb) begin
      ofs[pos] = d;
      pos = (pos + 1) % 4;
    end else if (!ena && enb && ex.ff) model.push_back(d);
    ex.ff  = model.size() != DEPTH;
    ex.almost_full_n = (DEPTH - model.size()) > {ofs[3], ofs[2]};
    ex.oe  = 1'b0;
    notes.push_back(ex);
    dcf_pin_model_i.wr_xfer(ena, enb, d);
  endtask

  task automatic do_rd(input logic ena, input logic enb);
    @(posedge clk_sys_in);  // Output enable change lands first
    if (ld_cfg && !enb_lvl && !ena && !enb) begin
      ex.d = ofs[pos];
      pos = (pos + 1) % 4;
    end else if (!ena && !enb && ex.ef) ex.d = model.pop_front();
    ex.ef  = model.size() != 0;
    ex.almost_empty_n = model.size() > {ofs[1], ofs[0]};
    ex.oe  = !oe_n && !ena && !enb;
    notes.push_back(ex);
    dcf_pin_model_i.rd_xfer(ena, enb);
  endtask

  // No access while master reset is low
  task automatic do_mr(input logic enb);
    dcf_pin_model_i.set_enb(enb);
    mr_n <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    mr_n <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    dcf_pin_model_i.set_enb(1'b1);
    ld_cfg  = !enb;
    enb_lvl = 1'b1;
    model.delete();
    ofs = '{9'h007, 9'h000, 9'h007, 9'h000};
    pos = 0;
    ex  = '{d: 9'h000, oe: 1'b0, ef: 1'b0, ff: 1'b1, almost_empty_n: 1'b0, almost_full_n: 1'b1};
    notes.push_back(ex);
    probe <= 1'b1;
    @(posedge clk_sys_in);
    probe <= 1'b0;
  endtask

  always @(posedge clk_sys_in) begin
    if (pm_done === 1'b1 || probe === 1'b1) chk_snap({rd_data, rd_oe, ef_n, ff_n, pae_n, paf_n});
  end

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (8000) @(posedge clk_sys_in);
    num_errors++;
    complete_run();
  end

  initial begin
    {resetn_in, oe_n, probe, ld_cfg, enb_lvl} = 5'h01;
    mr_n = 1'b1;
    ex   = '0;
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    do_mr(1'b1);
    seed = lfsr(seed);
    do_wr(1'b0, 1'b1, seed[8:0]);
    repeat (3) do_rd(1'b0, 1'b0);
    do_wr(1'b1, 1'b1, 9'h1AA);
    do_wr(1'b0, 1'b0, 9'h155);
    do_rd(1'b0, 1'b0);
    for (int i = 0; i < DEPTH + 1; i++) begin
      seed = lfsr(seed);
      do_wr(1'b0, 1'b1, seed[8:0]);
    end
    do_rd(1'b1, 1'b0);
    do_rd(1'b0, 1'b1);
    oe_n <= 1'b1;
    do_rd(1'b0, 1'b0);
    oe_n <= 1'b0;
    repeat (DEPTH) do_rd(1'b0, 1'b0);
    do_mr(1'b0);
    for (int i = 0; i < 5; i++) do_wr(1'b0, 1'b0, vals[i]);
    dcf_pin_model_i.set_enb(1'b0);
    enb_lvl = 1'b0;
    repeat (4) do_rd(1'b0, 1'b0);
    dcf_pin_model_i.set_enb(1'b1);
    enb_lvl = 1'b1;
    repeat (5) begin
      seed = lfsr(seed);
      do_wr(1'b0, 1'b1, seed[8:0]);
    end
    do_wr(1'b0, 1'b0, 9'h000);
    repeat (2) do_rd(1'b0, 1'b0);
    complete_run();
  end
endmodule // tb
`default_nettype wire

// file: core/dcf_fifo.sv
// Dual-clock 9-bit FIFO with empty, full and programmable almost flags.
// Assumes write and read clocks arrive as pins much slower than clk_sys_in,
// so each pin edge is seen after two-flop synchronisation.
//
// Behaviour
// RULE_01 - Array of 16k..128k nine-bit words chosen by parameter, separate pointers.
// RULE_02 - Outside party applies one master reset after power-up before any access.
// RULE_03 - Master reset empties the buffer, empty flag low, all flags valid.
// RULE_04 - All nine read-data outputs are low when master reset ends.
// RULE_05 - Outside party does not read or write during master reset.
// RULE_06 - Word stored on write edge with enable A low, B high, full high.
// RULE_07 - Next word presented on read edge with both read enables low, empty high.
// RULE_08 - Output enable high floats read data, low lets output register drive.
// RULE_09 - Read data driven only while the device is read-enabled.
// RULE_10 - Writes while full and reads while empty are ignored.
// RULE_11 - Last validly read word stays on outputs while empty.
// RULE_12 - Dual pin high during master reset makes it a second write enable.
// RULE_13 - Dual pin low during master reset makes it the offset load strobe.
// RULE_14 - In load configuration write enable A alone gates data writes.
// RULE_15 - Four nine-bit offset registers reachable through data pins while load low.
// RULE_16 - Load and enable A low write offsets in order empty lo/hi, full lo/hi, wrap.
// RULE_17 - Raising load resumes normal work, sequence position is kept.
// RULE_18 - Load low with read enables low reads offsets in the same order.
// RULE_19 - Outside party avoids writing and reading offsets at once.
// RULE_20 - Almost-empty flag updates only on read edges.
// RULE_21 - Almost-full flag updates only on write edges.
// RULE_22 - Almost-empty low at n or fewer words, high from n+1 upward.
// RULE_23 - Almost-full high once free locations exceed m, low otherwise.
// RULE_24 - Both offsets default to seven words after reset.
// RULE_25 - Full flag low when every location is used, updates on write edges.
// RULE_26 - Pointers wrap to zero past last location, count is their difference.
`timescale 1ns/100ps
`default_nettype none

module dcf_fifo #(
  parameter int DEPTH_LOG2 = dcf_pkg::DEPTH_LOG2_DFLT  // 14..17
) (
  input  wire logic                       clk_sys_in,                // System clock, 10 MHz
  input  wire logic                       resetn_in,                 // Chip reset, async, active low
  input  wire logic                       master_reset_n_in,         // Master reset pin, active low
  input  wire logic                       write_clk_in,              // Write clock pin
  input  wire logic                       write_enable_a_n_in,       // Write enable A, active low
  input  wire logic                       write_enable_b_or_load_in, // Write enable B or load strobe
  input  wire logic [dcf_pkg::DATA_W-1:0] write_data_in,             // Write data pins
  input  wire logic                       read_clk_in,               // Read clock pin
  input  wire logic                       read_enable_a_n_in,        // Read enable A, active low
  input  wire logic                       read_enable_b_n_in,        // Read enable B, active low
  input  wire logic                       output_enable_n_in,        // Output enable, active low
  output logic      [dcf_pkg::DATA_W-1:0] read_data_out,             // Read data, registered
  output logic                            read_data_oe_out,          // Read data drive enable
  output logic                            empty_flag_n_out,          // Empty, active low
  output logic                            full_flag_n_out,           // Full, active low
  output logic                            almost_empty_n_out,        // Almost empty, active low
  output logic                            almost_full_n_out          // Almost full, active low
);

  localparam int                AW      = DEPTH_LOG2;
  localparam logic [AW:0]       DEPTH_C = {1'b1, {AW{1'b0}}};
  localparam int                EW      = dcf_pkg::EXT_W;

  // Word count from two pointers carrying a wrap bit
  function automatic logic [AW:0] fill_of(input logic [AW:0] wp, input logic [AW:0] rp);
    fill_of = wp - rp;  // [RULE_26]
  endfunction

  // Widen a count for comparison with an offset pair
  function automatic logic [EW-1:0] ext_of(input logic [AW:0] c);
    ext_of = {{(EW-AW-1){1'b0}}, c};
  endfunction

  // Next position in the offset register sequence
  function automatic dcf_pkg::dcf_ofs_sel_t next_sel(input dcf_pkg::dcf_ofs_sel_t s);
    unique case (s)
      dcf_pkg::OFS_EMPTY_LO: next_sel = dcf_pkg::OFS_EMPTY_HI;
      dcf_pkg::OFS_EMPTY_HI: next_sel = dcf_pkg::OFS_FULL_LO;
      dcf_pkg::OFS_FULL_LO:  next_sel = dcf_pkg::OFS_FULL_HI;
      dcf_pkg::OFS_FULL_HI:  next_sel = dcf_pkg::OFS_EMPTY_LO;  // [RULE_16]
    endcase
  endfunction

  // ---------------- Pin synchronisation ----------------
  dcf_pkg::dcf_wr_pins_t wr_raw;
  dcf_pkg::dcf_wr_pins_t wr_pins;
  dcf_pkg::dcf_rd_pins_t rd_raw;
  dcf_pkg::dcf_rd_pins_t rd_pins;
  logic                  run;

  assign wr_raw = '{clk: write_clk_in, ena_n: write_enable_a_n_in,
                    enb_ld: write_enable_b_or_load_in, data: write_data_in};
  assign rd_raw = '{clk: read_clk_in, ena_n: read_enable_a_n_in,
                    enb_n: read_enable_b_n_in, oe_n: output_enable_n_in};

  dcf_pin_sync #(
    .WIDTH     ($bits(dcf_pkg::dcf_wr_pins_t)),
    .RESET_VAL (dcf_pkg::WR_PINS_RST)
  ) u_wr_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pins_in    (wr_raw),
    .synced_out (wr_pins)
  );

  dcf_pin_sync #(
    .WIDTH     ($bits(dcf_pkg::dcf_rd_pins_t)),
    .RESET_VAL (dcf_pkg::RD_PINS_RST)
  ) u_rd_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pins_in    (rd_raw),
    .synced_out (rd_pins)
  );

  // Held in master reset during chip reset, so no stray clock edge counts
  dcf_pin_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_mr_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pins_in    (master_reset_n_in),
    .synced_out (run)
  );

  // ---------------- Clock edge detection ----------------
  logic wr_clk_d;
  logic rd_clk_d;
  logic wr_edge;
  logic rd_edge;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_clk_d <= 1'b0;
      rd_clk_d <= 1'b0;
    end else begin
      wr_clk_d <= wr_pins.clk;
      rd_clk_d <= rd_pins.clk;
    end
  end

  assign wr_edge = wr_pins.clk & ~wr_clk_d;
  assign rd_edge = rd_pins.clk & ~rd_clk_d;

  // ---------------- Configuration caught during master reset ----------------
  logic load_mode;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      load_mode <= dcf_pkg::LOAD_MODE_RST;
    end else if (!run) begin
      load_mode <= ~wr_pins.enb_ld;  // [RULE_12] [RULE_13]
    end
  end

  // ---------------- Request decode ----------------
  logic empty_n;
  logic full_n;
  logic rd_enabled;
  logic wr_fifo;
  logic wr_ofs;
  logic rd_ofs;
  logic rd_fifo;

  assign rd_enabled = ~rd_pins.ena_n & ~rd_pins.enb_n;

  // Same level works as second enable or as load high in load mode
  assign wr_fifo = wr_edge & run & ~wr_pins.ena_n & wr_pins.enb_ld & full_n;  // [RULE_06] [RULE_10] [RULE_14]
  assign wr_ofs  = wr_edge & run & load_mode & ~wr_pins.ena_n & ~wr_pins.enb_ld;  // [RULE_15] [RULE_16]
  assign rd_ofs  = rd_edge & run & load_mode & ~wr_pins.enb_ld & rd_enabled;  // [RULE_18]
  assign rd_fifo = rd_edge & run & rd_enabled & empty_n & ~rd_ofs;  // [RULE_07] [RULE_10]

  // ---------------- Offset registers ----------------
  logic [dcf_pkg::OFFS_W-1:0] empty_threshold_low_part;
  logic [dcf_pkg::OFFS_W-1:0] empty_threshold_high_part;
  logic [dcf_pkg::OFFS_W-1:0] full_threshold_low_part;
  logic [dcf_pkg::OFFS_W-1:0] full_threshold_high_part;
  dcf_pkg::dcf_ofs_sel_t      ofs_sel;
  logic [dcf_pkg::OFFS_W-1:0] ofs_rd_word;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      empty_threshold_low_part  <= dcf_pkg::EMPTY_OFFS_LO_RST;  // [RULE_24]
      empty_threshold_high_part <= dcf_pkg::EMPTY_OFFS_HI_RST;
      full_threshold_low_part   <= dcf_pkg::FULL_OFFS_LO_RST;
      full_threshold_high_part  <= dcf_pkg::FULL_OFFS_HI_RST;
    end else if (!run) begin
      empty_threshold_low_part  <= dcf_pkg::EMPTY_OFFS_LO_RST;  // [RULE_24]
      empty_threshold_high_part <= dcf_pkg::EMPTY_OFFS_HI_RST;
      full_threshold_low_part   <= dcf_pkg::FULL_OFFS_LO_RST;
      full_threshold_high_part  <= dcf_pkg::FULL_OFFS_HI_RST;
    end else if (wr_ofs) begin
      unique case (ofs_sel)
        dcf_pkg::OFS_EMPTY_LO: empty_threshold_low_part  <= wr_pins.data;  // [RULE_16]
        dcf_pkg::OFS_EMPTY_HI: empty_threshold_high_part <= wr_pins.data;
        dcf_pkg::OFS_FULL_LO:  full_threshold_low_part   <= wr_pins.data;
        dcf_pkg::OFS_FULL_HI:  full_threshold_high_part  <= wr_pins.data;
      endcase
    end
  end

  // Shared position; it advances once even if a write and a read land in one cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ofs_sel <= dcf_pkg::OFS_EMPTY_LO;
    end else if (!run) begin
      ofs_sel <= dcf_pkg::OFS_EMPTY_LO;
    end else if (wr_ofs || rd_ofs) begin
      ofs_sel <= next_sel(ofs_sel);  // [RULE_17] [RULE_18]
    end
  end

  always_comb begin
    unique case (ofs_sel)
      dcf_pkg::OFS_EMPTY_LO: ofs_rd_word = empty_threshold_low_part;
      dcf_pkg::OFS_EMPTY_HI: ofs_rd_word = empty_threshold_high_part;
      dcf_pkg::OFS_FULL_LO:  ofs_rd_word = full_threshold_low_part;
      dcf_pkg::OFS_FULL_HI:  ofs_rd_word = full_threshold_high_part;
    endcase
  end

  // ---------------- Pointers and storage ----------------
  logic [AW:0]                wr_ptr;
  logic [AW:0]                rd_ptr;
  logic [AW:0]                next_wr_ptr;
  logic [AW:0]                next_rd_ptr;
  logic [AW:0]                next_fill;
  logic [dcf_pkg::DATA_W-1:0] mem_word;

  assign next_wr_ptr = wr_fifo ? wr_ptr + 1'b1 : wr_ptr;  // [RULE_26]
  assign next_rd_ptr = rd_fifo ? rd_ptr + 1'b1 : rd_ptr;
  assign next_fill   = fill_of(next_wr_ptr, next_rd_ptr);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (!run) begin
      wr_ptr <= '0;  // [RULE_03]
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  dcf_ram #(
    .AW (AW),
    .DW (dcf_pkg::DATA_W)
  ) u_ram (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (wr_fifo),
    .wr_idx_in   (wr_ptr[AW-1:0]),
    .wr_data_in  (wr_pins.data),
    .rd_idx_in   (rd_ptr[AW-1:0]),
    .rd_data_out (mem_word)
  );  // [RULE_01]

  // ---------------- Output register ----------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      read_data_out <= dcf_pkg::READ_DATA_RST;
    end else if (!run) begin
      read_data_out <= dcf_pkg::READ_DATA_RST;  // [RULE_04]
    end else if (rd_ofs) begin
      read_data_out <= ofs_rd_word;  // [RULE_18]
    end else if (rd_fifo) begin
      read_data_out <= mem_word;  // [RULE_07]
    end
    // Otherwise the last valid word is kept [RULE_11]
  end

  // Drives only when enabled and read-enabled
  assign read_data_oe_out = ~rd_pins.oe_n & rd_enabled;  // [RULE_08] [RULE_09]

  // ---------------- Status flags ----------------
  logic [EW-1:0] empty_thr;
  logic [EW-1:0] full_thr;

  assign empty_thr = {1'b0, empty_threshold_high_part, empty_threshold_low_part};
  assign full_thr  = {1'b0, full_threshold_high_part, full_threshold_low_part};

  // Read-side flags change only on read clock edges
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      empty_n            <= dcf_pkg::EMPTY_FLAG_N_RST;
      almost_empty_n_out <= dcf_pkg::AEMPTY_N_RST;
    end else if (!run) begin
      empty_n            <= dcf_pkg::EMPTY_FLAG_N_RST;  // [RULE_03]
      almost_empty_n_out <= dcf_pkg::AEMPTY_N_RST;
    end else if (rd_edge) begin
      empty_n            <= (next_fill != '0);
      almost_empty_n_out <= (ext_of(next_fill) > empty_thr);  // [RULE_20] [RULE_22]
    end
  end

  // Write-side flags change only on write clock edges
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      full_n            <= dcf_pkg::FULL_FLAG_N_RST;
      almost_full_n_out <= dcf_pkg::AFULL_N_RST;
    end else if (!run) begin
      full_n            <= dcf_pkg::FULL_FLAG_N_RST;  // [RULE_03]
      almost_full_n_out <= dcf_pkg::AFULL_N_RST;
    end else if (wr_edge) begin
      full_n            <= (next_fill != DEPTH_C);  // [RULE_25]
      almost_full_n_out <= (ext_of(DEPTH_C - next_fill) > full_thr);  // [RULE_21] [RULE_23]
    end
  end

  assign empty_flag_n_out = empty_n;
  assign full_flag_n_out  = full_n;

endmodule // dcf_fifo

`default_nettype wire

// file: core/dcf_pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes the bundle is read only at the second stage output.
`timescale 1ns/100ps
`default_nettype none

module dcf_pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys_in,   // System clock
  input  wire logic             resetn_in,    // Async reset, active low
  input  wire logic [WIDTH-1:0] pins_in,      // Raw pin levels
  output logic      [WIDTH-1:0] synced_out    // Second stage levels
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1     <= RESET_VAL;
      synced_out <= RESET_VAL;
    end else begin
      stage1     <= pins_in;
      synced_out <= stage1;
    end
  end

endmodule // dcf_pin_sync

`default_nettype wire

// file: core/dcf_ram.sv
// Flip-flop storage array with one write port and one indexed read port.
// Assumes the controller never writes and reads one index in a cycle it cares about.
`timescale 1ns/100ps
`default_nettype none

module dcf_ram #(
  parameter int AW = dcf_pkg::DEPTH_LOG2_DFLT,
  parameter int DW = dcf_pkg::DATA_W
) (
  input  wire logic          clk_sys_in,  // System clock
  input  wire logic          wr_en_in,    // Store strobe
  input  wire logic [AW-1:0] wr_idx_in,   // Store index
  input  wire logic [DW-1:0] wr_data_in,  // Store word
  input  wire logic [AW-1:0] rd_idx_in,   // Fetch index
  output logic      [DW-1:0] rd_data_out  // Fetched word
);

  logic [DW-1:0] mem [1 << AW];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_idx_in];

endmodule // dcf_ram

`default_nettype wire

// file: inc/dcf_pkg.sv
// Shared constants, types and pin bundles for the dual-clock FIFO block.
// Assumes every consumer refers to items as dcf_pkg::name.
`default_nettype none

package dcf_pkg;

  // Word and offset register geometry
  localparam int DATA_W          = 9;
  localparam int OFFS_W          = 9;
  localparam int THR_W           = 2 * OFFS_W;
  localparam int EXT_W           = THR_W + 1;

  // Depth as a power of two: 14..17 gives 16k..128k words
  localparam int DEPTH_LOG2_DFLT = 14;

  // Offset register values after reset (threshold of seven words)
  localparam logic [OFFS_W-1:0] EMPTY_OFFS_LO_RST = 9'h007;
  localparam logic [OFFS_W-1:0] EMPTY_OFFS_HI_RST = 9'h000;
  localparam logic [OFFS_W-1:0] FULL_OFFS_LO_RST  = 9'h007;
  localparam logic [OFFS_W-1:0] FULL_OFFS_HI_RST  = 9'h000;

  // Values after reset of load mode, flags and read data
  localparam logic [DATA_W-1:0] READ_DATA_RST     = 9'h000;
  localparam logic              EMPTY_FLAG_N_RST  = 1'b0;
  localparam logic              FULL_FLAG_N_RST   = 1'b1;
  localparam logic              AEMPTY_N_RST      = 1'b0;
  localparam logic              AFULL_N_RST       = 1'b1;
  localparam logic              LOAD_MODE_RST     = 1'b0;

  // Offset register access sequence
  typedef enum {
    OFS_EMPTY_LO,
    OFS_EMPTY_HI,
    OFS_FULL_LO,
    OFS_FULL_HI
  } dcf_ofs_sel_t;

  // Write-side pins
  typedef struct packed {
    logic              clk;
    logic              ena_n;
    logic              enb_ld;
    logic [DATA_W-1:0] data;
  } dcf_wr_pins_t;

  // Read-side pins
  typedef struct packed {
    logic clk;
    logic ena_n;
    logic enb_n;
    logic oe_n;
  } dcf_rd_pins_t;

  // Idle pin levels held by the synchronisers during chip reset
  localparam dcf_wr_pins_t WR_PINS_RST = '{clk: 1'b0, ena_n: 1'b1, enb_ld: 1'b1, data: 9'h000};
  localparam dcf_rd_pins_t RD_PINS_RST = '{clk: 1'b0, ena_n: 1'b1, enb_n: 1'b1, oe_n: 1'b1};

endpackage

`default_nettype wire
